/* File: hdl/bcc_apb_regs.sv */
// apb slave: control word and live status of the controller
`timescale 1ns/1ns
`include "bcc_map.svh"
module bcc_apb_regs (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mask_on_first_ack,
  input  wire logic [31:0] status_word
);
  logic [31:0] ctrl_r;
  logic [31:0] prdata_r;
  logic        err_r;

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  wire access   = psel & penable;
  wire hit_ctrl = (paddr == `BCC_REG_CTRL);
  wire hit_stat = (paddr == `BCC_REG_STATUS);
  wire mapped   = hit_ctrl | hit_stat;
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r : hit_stat ? status_word : 32'h0000_0000;

  // zero-wait slave; unmapped addresses answer with pslverr
  assign pready             = 1'b1;
  assign prdata             = prdata_r;
  assign pslverr            = err_r;
  assign mask_on_first_ack  = ctrl_r[0];

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  // read data registered in setup so it is stable during access
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r   <= `BCC_CTRL_RESET;
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else begin
      if (access && pwrite && hit_ctrl) ctrl_r <= {31'h0000_0000, pwdata[0]};
      if (psel && !penable) begin
        prdata_r <= rd_mux;
        err_r    <= !mapped;
      end
    end
  end
endmodule : bcc_apb_regs

/* File: hdl/bcc_core.sv */
// bus command controller: status decode, latch strobe, command and control outputs
//
// Operation
// [RQ1] passive status keeps all command strobes high
// [RQ2] address strobe active high, latches on fall
// [RQ3] transceiver enable active high
// [RQ4] direction high for writes, low reads
// [RQ5] commands enabled 110 to 250 ns after grant
// [RQ6] grant release floats command drivers immediately
// [RQ7] io bus mode: io commands ignore grant
// [RQ8] qualifier low forces strobes and enables inactive
// [RQ9] strap high io mode, low system mode
// [RQ10] early io write low with read timing
// [RQ11] io write strobe low accepts data
// [RQ12] io read strobe low drives data
// [RQ13] early memory write low with read timing
// [RQ14] memory write strobe low stores data
// [RQ15] memory read strobe low drives data
// [RQ16] interrupt acknowledge strobe low requests vector
// [RQ17] system mode: cascade gate high in interrupts
// [RQ18] io mode: peripheral enable active low
// [RQ19] status code decode table
// [RQ20] io mode: io commands start at once
// [RQ21] detect cycle start, strobe address, then commands
`timescale 1ns/1ns
`include "bcc_map.svh"
module bcc_core #(
  parameter int GRANT_MIN_CYC = `BCC_GRANT_MIN_CYC,
  parameter int GRANT_MAX_CYC = `BCC_GRANT_MAX_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        status_code_bit0,
  input  wire logic        status_code_bit1,
  input  wire logic        status_code_bit2,
  input  wire logic        bus_grant_in_n,
  input  wire logic        command_qualifier,
  input  wire logic        mode_strap,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             address_strobe,
  output logic             transceiver_enable,
  output logic             transfer_direction,
  output logic             cascade_or_peripheral_enable,
  output logic             mem_read_strobe_n,
  output logic             mem_write_strobe_n,
  output logic             early_mem_write_strobe_n,
  output logic             io_read_strobe_n,
  output logic             io_write_strobe_n,
  output logic             early_io_write_strobe_n,
  output logic             interrupt_ack_strobe_n,
  output logic             mem_cmd_oe,
  output logic             io_cmd_oe
);
  bcc_sync_if sync ();
  bcc_pkg::bcc_state_type state_r;
  bcc_pkg::bcc_state_type state_nxt;
  logic [2:0] code_r;
  logic       ale_r;
  logic       late_r;
  logic       dir_r;
  logic       xcvr_en_r;
  logic       periph_en_r;
  logic       casc_gate_r;
  logic       ack_seen_r;
  logic [6:0] strb_r;
  logic [`BCC_CNT_W-1:0] grant_cnt_r;
  logic       grant_ok_r;
  logic       mask_first;

  // --------------------------------------------------------------------
  // pin capture
  // --------------------------------------------------------------------
  // passive code and released grant at reset, so nothing fires early
  bcc_pin_sync #(.W(6)) u_sync (
    .mclk    (mclk),
    .rstn    (rstn),
    .pin_in  ({mode_strap, command_qualifier, bus_grant_in_n,
               status_code_bit2, status_code_bit1, status_code_bit0}),
    .rst_val (6'b00_1111),
    .sync    (sync)
  );

  bcc_apb_regs u_regs (
    .mclk               (mclk),
    .rstn               (rstn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .mask_on_first_ack  (mask_first),
    .status_word        ({22'h00_0000, grant_ok_r, sync.mode_strap, sync.command_qualifier,
                          sync.bus_grant_n, state_r, code_r, ack_seen_r})
  );

  // --------------------------------------------------------------------
  // status decode
  // --------------------------------------------------------------------
  wire [2:0] code     = sync.status_code;
  wire       io_mode  = sync.mode_strap;                              // RQ9
  wire       passive  = (code == `BCC_ST_PASSIVE);
  wire       halt     = (code == `BCC_ST_HALT);
  wire       start    = !passive && !halt;
  wire       is_iack  = (code_r == `BCC_ST_IACK);                     // RQ19
  wire       is_iord  = (code_r == `BCC_ST_IORD);                     // RQ19
  wire       is_iowr  = (code_r == `BCC_ST_IOWR);                     // RQ19
  wire       is_mrd   = (code_r == `BCC_ST_CODE) || (code_r == `BCC_ST_MRD); // RQ19
  wire       is_mwr   = (code_r == `BCC_ST_MWR);                      // RQ19
  wire       is_write = is_iowr || is_mwr;
  wire       is_io    = is_iack || is_iord || is_iowr;
  wire       qual     = sync.command_qualifier;

  // --------------------------------------------------------------------
  // cycle sequencer
  // --------------------------------------------------------------------
  // idle -> latch (one cycle of address strobe) -> active until passive
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bcc_pkg::BCC_IDLE:   if (start) state_nxt = bcc_pkg::BCC_LATCH; // RQ21
      bcc_pkg::BCC_LATCH:  state_nxt = bcc_pkg::BCC_ACTIVE;
      bcc_pkg::BCC_ACTIVE: if (passive) state_nxt = bcc_pkg::BCC_IDLE; // RQ1
      default:             state_nxt = bcc_pkg::BCC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= bcc_pkg::BCC_IDLE;
      code_r  <= `BCC_ST_PASSIVE;
      ale_r   <= 1'b0;
      late_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == bcc_pkg::BCC_IDLE && start) code_r <= code;
      else if (state_nxt == bcc_pkg::BCC_IDLE) code_r <= `BCC_ST_PASSIVE;
      ale_r  <= (state_r == bcc_pkg::BCC_IDLE) && start;              // RQ2 RQ21
      late_r <= (state_nxt == bcc_pkg::BCC_ACTIVE) && (state_r == bcc_pkg::BCC_ACTIVE);
    end
  end

  // --------------------------------------------------------------------
  // bus grant delay
  // --------------------------------------------------------------------
  // counts grant-low cycles; release drops it at once
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      grant_cnt_r <= '0;
      grant_ok_r  <= 1'b0;
    end else if (sync.bus_grant_n) begin
      grant_cnt_r <= '0;                                              // RQ6
      grant_ok_r  <= 1'b0;                                            // RQ6
    end else begin
      if (grant_cnt_r < GRANT_MIN_CYC[`BCC_CNT_W-1:0]) grant_cnt_r <= grant_cnt_r + 1'b1;
      grant_ok_r <= (grant_cnt_r >= GRANT_MIN_CYC[`BCC_CNT_W-1:0] - 1'b1); // RQ5
    end
  end

  // the synchroniser adds four cycles before the counter sees the edge
  assign mem_cmd_oe = grant_ok_r;                                     // RQ5 RQ6
  assign io_cmd_oe  = io_mode ? 1'b1 : grant_ok_r;                    // RQ7

  // --------------------------------------------------------------------
  // command strobes
  // --------------------------------------------------------------------
  // order: ack, iord, iowr, early iowr, mrd, mwr, early mwr
  // grant gating lives in the driver enables, so strobes never wait on it
  wire act   = (state_r == bcc_pkg::BCC_ACTIVE) && qual;              // RQ8 RQ1
  logic [6:0] strb_nxt;
  assign strb_nxt[0] = act && is_iack;                                // RQ16
  assign strb_nxt[1] = act && is_iord;                                // RQ12 RQ20
  assign strb_nxt[2] = act && is_iowr && late_r;                      // RQ11
  assign strb_nxt[3] = act && is_iowr;                                // RQ10
  assign strb_nxt[4] = act && is_mrd;                                 // RQ15
  assign strb_nxt[5] = act && is_mwr && late_r;                       // RQ14
  assign strb_nxt[6] = act && is_mwr;                                 // RQ13

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) strb_r <= 7'h00;
    else       strb_r <= strb_nxt;
  end

  assign interrupt_ack_strobe_n   = ~strb_r[0];                       // RQ16
  assign io_read_strobe_n         = ~strb_r[1];                       // RQ12
  assign io_write_strobe_n        = ~strb_r[2];                       // RQ11
  assign early_io_write_strobe_n  = ~strb_r[3];                       // RQ10
  assign mem_read_strobe_n        = ~strb_r[4];                       // RQ15
  assign mem_write_strobe_n       = ~strb_r[5];                       // RQ14
  assign early_mem_write_strobe_n = ~strb_r[6];                       // RQ13

  // --------------------------------------------------------------------
  // control outputs
  // --------------------------------------------------------------------
  // in io mode io cycles steer the peripheral enable instead of the main one
  wire io_path = io_mode && is_io;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dir_r       <= 1'b0;
      xcvr_en_r   <= 1'b0;
      periph_en_r <= 1'b0;
      casc_gate_r <= 1'b0;
      ack_seen_r  <= 1'b0;
    end else begin
      dir_r       <= (state_r != bcc_pkg::BCC_IDLE) && is_write;      // RQ4
      xcvr_en_r   <= act && !io_path;                                 // RQ3 RQ8
      periph_en_r <= act && io_path;                                  // RQ18 RQ20 RQ8
      // cascade gate during latch of an interrupt cycle, optionally
      // masked on the first of the back-to-back pair
      casc_gate_r <= !io_mode && (state_nxt == bcc_pkg::BCC_LATCH) && (code == `BCC_ST_IACK)
                     && !(mask_first && !ack_seen_r);                 // RQ17
      if (state_r == bcc_pkg::BCC_LATCH && is_iack) ack_seen_r <= !ack_seen_r;
      else if (state_r == bcc_pkg::BCC_LATCH) ack_seen_r <= 1'b0;
    end
  end

  assign address_strobe               = ale_r;                        // RQ2
  assign transceiver_enable           = xcvr_en_r;                    // RQ3
  assign transfer_direction           = dir_r;                        // RQ4
  assign cascade_or_peripheral_enable = io_mode ? ~periph_en_r : casc_gate_r; // RQ17 RQ18
endmodule : bcc_core

/* File: hdl/bcc_map.svh */
// offsets, timing figures and cycle counts for the bus command controller
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH
`define BCC_CLK_PERIOD_NS     8
`define BCC_GRANT_MIN_NS      110
`define BCC_GRANT_MAX_NS      250
// least time rounds up, longest rounds down
`define BCC_GRANT_MIN_CYC     ((`BCC_GRANT_MIN_NS + `BCC_CLK_PERIOD_NS - 1) / `BCC_CLK_PERIOD_NS)
`define BCC_GRANT_MAX_CYC     (`BCC_GRANT_MAX_NS / `BCC_CLK_PERIOD_NS)
`define BCC_CNT_W             5
// status codes
`define BCC_ST_IACK           3'b000
`define BCC_ST_IORD           3'b001
`define BCC_ST_IOWR           3'b010
`define BCC_ST_HALT           3'b011
`define BCC_ST_CODE           3'b100
`define BCC_ST_MRD            3'b101
`define BCC_ST_MWR            3'b110
`define BCC_ST_PASSIVE        3'b111
// register map of the apb slave
`define BCC_REG_CTRL          12'h000
`define BCC_REG_STATUS        12'h004
`define BCC_CTRL_RESET        32'h0000_0000
`endif

/* File: hdl/bcc_pin_sync.sv */
// three-flop pin synchroniser: a change counts once stages two and three agree
`timescale 1ns/1ns
module bcc_pin_sync #(
  parameter int W = 6
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  input  wire logic [W-1:0] rst_val,
  bcc_sync_if.src           sync
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic         armed_r;

  // --------------------------------------------------------------------
  // capture chain
  // --------------------------------------------------------------------
  // stage one is read only by stage two
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // --------------------------------------------------------------------
  // agreement filter
  // --------------------------------------------------------------------
  // rst_val is loaded by the clock, never by the async reset branch
  genvar g;
  for (g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (!armed_r) begin
        out_r[g] <= rst_val[g];
      end else if (s2_r[g] == s3_r[g]) begin
        out_r[g] <= s3_r[g];
      end
    end
  end

  // arm only after four edges so the chain holds real pin values
  logic [1:0] warm_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      warm_r  <= 2'd0;
      armed_r <= 1'b0;
    end else begin
      if (warm_r != 2'd3) warm_r <= warm_r + 2'd1;
      armed_r <= (warm_r == 2'd3);
    end
  end

  assign sync.status_code       = out_r[2:0];
  assign sync.bus_grant_n       = out_r[3];
  assign sync.command_qualifier = out_r[4];
  assign sync.mode_strap        = out_r[5];
endmodule : bcc_pin_sync

/* File: hdl/bcc_pkg.sv */
// types shared by the bus command controller modules
package bcc_pkg;
  typedef enum logic [1:0] {
    BCC_IDLE   = 2'b00,
    BCC_LATCH  = 2'b01,
    BCC_ACTIVE = 2'b10
  } bcc_state_type;

  typedef enum logic [2:0] {
    BCC_CMD_IACK = 3'b000,
    BCC_CMD_IORD = 3'b001,
    BCC_CMD_IOWR = 3'b010,
    BCC_CMD_NONE = 3'b011,
    BCC_CMD_MRD  = 3'b100,
    BCC_CMD_MWR  = 3'b110
  } bcc_cmd_type;
endpackage : bcc_pkg

/* File: hdl/bcc_sync_if.sv */
// carrier between the pin synchroniser and the controller core
`timescale 1ns/1ns
interface bcc_sync_if;
  logic [2:0] status_code;
  logic       bus_grant_n;
  logic       command_qualifier;
  logic       mode_strap;
  modport src (output status_code, output bus_grant_n, output command_qualifier, output mode_strap);
  modport dst (input status_code, input bus_grant_n, input command_qualifier, input mode_strap);
endinterface : bcc_sync_if

/* File: tb/bcc_core_chk.sv */
// concurrent checks on the bus command controller core ports
`timescale 1ns/1ns
module bcc_core_chk #(
  parameter int GRANT_MIN_CYC = 14,
  parameter int GRANT_MAX_CYC = 31
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic status_code_bit0,
  input wire logic status_code_bit1,
  input wire logic status_code_bit2,
  input wire logic bus_grant_in_n,
  input wire logic command_qualifier,
  input wire logic mode_strap,
  input wire logic address_strobe,
  input wire logic transceiver_enable,
  input wire logic transfer_direction,
  input wire logic cascade_or_peripheral_enable,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic early_mem_write_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic early_io_write_strobe_n,
  input wire logic interrupt_ack_strobe_n,
  input wire logic mem_cmd_oe,
  input wire logic io_cmd_oe
);
  // ----
  // helpers and assertions
  // ----
  logic [5:0]      gcnt_r;
  wire logic [2:0] stat = {status_code_bit2, status_code_bit1, status_code_bit0};
  wire logic [6:0] cmd  = {mem_read_strobe_n, mem_write_strobe_n, early_mem_write_strobe_n, io_read_strobe_n,
                           io_write_strobe_n, early_io_write_strobe_n, interrupt_ack_strobe_n};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // cycles the grant has been low; saturates so a long grant never wraps
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      gcnt_r <= 6'h00;
    else if (bus_grant_in_n)
      gcnt_r <= 6'h00;
    else if (gcnt_r != 6'h3f)
      gcnt_r <= gcnt_r + 6'h01;
  end

  // margins of 6 to 8 cycles cover the three-flop pin synchroniser
  passive_idle_a: assert property (stat == 3'h7 [*8] |-> cmd == 7'h7f)
    else $error("command strobe active during passive status");
  strobe_pulse_a: assert property (address_strobe |=> !address_strobe)
    else $error("address strobe longer than one cycle");
  strobe_first_a: assert property ($fell(mem_read_strobe_n) |-> $past(address_strobe, 2))
    else $error("memory read without address strobe two cycles before");
  write_dir_a: assert property ($fell(early_io_write_strobe_n) || $fell(early_mem_write_strobe_n)
    |-> transfer_direction)
    else $error("write strobe with receive direction");
  early_write_a: assert property ($fell(io_write_strobe_n) |-> !$past(early_io_write_strobe_n))
    else $error("io write before early io write");
  qual_block_a: assert property (!command_qualifier [*8] |-> cmd == 7'h7f && !transceiver_enable
    && (!mode_strap || cascade_or_peripheral_enable))
    else $error("output active while qualifier low");
  grant_window_a: assert property ($rose(mem_cmd_oe) |-> gcnt_r >= GRANT_MIN_CYC && gcnt_r <= GRANT_MAX_CYC)
    else $error("memory commands enabled outside grant window");
  grant_float_a: assert property ($rose(bus_grant_in_n) |-> ##[1:6] !mem_cmd_oe)
    else $error("memory commands still driven after grant release");
  io_mode_oe_a: assert property (mode_strap [*8] |-> io_cmd_oe)
    else $error("io commands floated in io bus mode");
  cascade_gate_a: assert property (!mode_strap [*6] ##0 cascade_or_peripheral_enable |-> address_strobe
    && stat == 3'h0)
    else $error("cascade gate outside interrupt address strobe");
endmodule : bcc_core_chk

bind bcc_core bcc_core_chk #(.GRANT_MIN_CYC(GRANT_MIN_CYC), .GRANT_MAX_CYC(GRANT_MAX_CYC)) i_bcc_core_chk (
  .mclk(mclk), .rstn(rstn), .status_code_bit0(status_code_bit0), .status_code_bit1(status_code_bit1),
  .status_code_bit2(status_code_bit2), .bus_grant_in_n(bus_grant_in_n), .command_qualifier(command_qualifier),
  .mode_strap(mode_strap), .address_strobe(address_strobe), .transceiver_enable(transceiver_enable),
  .transfer_direction(transfer_direction), .cascade_or_peripheral_enable(cascade_or_peripheral_enable),
  .mem_read_strobe_n(mem_read_strobe_n), .mem_write_strobe_n(mem_write_strobe_n),
  .early_mem_write_strobe_n(early_mem_write_strobe_n), .io_read_strobe_n(io_read_strobe_n),
  .io_write_strobe_n(io_write_strobe_n), .early_io_write_strobe_n(early_io_write_strobe_n),
  .interrupt_ack_strobe_n(interrupt_ack_strobe_n), .mem_cmd_oe(mem_cmd_oe), .io_cmd_oe(io_cmd_oe));

/* File: tb/bcc_proc_model.sv */
// processor status lines and bus arbiter model feeding the controller
`timescale 1ns/1ns
module bcc_proc_model (
  input  wire logic mclk,
  output logic      status_code_bit0,
  output logic      status_code_bit1,
  output logic      status_code_bit2,
  output logic      bus_grant_in_n
);
  // ----
  // status and grant drivers
  // ----
  // power up passive with the bus not granted
  initial begin
    {status_code_bit2, status_code_bit1, status_code_bit0} = 3'h7;
    bus_grant_in_n = 1'b1;
  end

  // a new code goes out just after an edge, as the processor launches it
  task automatic put_status(input logic [2:0] code);
    @(posedge mclk);
    {status_code_bit2, status_code_bit1, status_code_bit0} <= code;
  endtask : put_status

  // the arbiter grants and releases the shared bus
  task automatic set_grant(input logic g_n);
    @(posedge mclk);
    bus_grant_in_n <= g_n;
  endtask : set_grant
endmodule : bcc_proc_model

/* File: tb/bus_command_controller_test.sv */
// self-checking bench for the bus command controller core
`timescale 1ns/1ns
`include "bcc_map.svh"
module bus_command_controller_test;
  // ----
  // pins, models and tests
  // ----
  logic        mclk, rstn, qual, strap, psel, penable, pwrite, pready, pslverr;
  logic        st0, st1, st2, gnt_n, ale, xen, dir, cope, mrd, mwr, emwr, iord, iowr, eiowr, iack, moe, ioe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int          err_count, checks_done;

  bcc_core i_bcc_core (.mclk(mclk), .rstn(rstn), .status_code_bit0(st0), .status_code_bit1(st1),
    .status_code_bit2(st2), .bus_grant_in_n(gnt_n), .command_qualifier(qual), .mode_strap(strap), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .address_strobe(ale), .transceiver_enable(xen), .transfer_direction(dir),
    .cascade_or_peripheral_enable(cope), .mem_read_strobe_n(mrd), .mem_write_strobe_n(mwr),
    .early_mem_write_strobe_n(emwr), .io_read_strobe_n(iord), .io_write_strobe_n(iowr),
    .early_io_write_strobe_n(eiowr), .interrupt_ack_strobe_n(iack), .mem_cmd_oe(moe), .io_cmd_oe(ioe));
  bcc_proc_model i_bcc_proc_model (.mclk(mclk), .status_code_bit0(st0), .status_code_bit1(st1),
    .status_code_bit2(st2), .bus_grant_in_n(gnt_n));

  // floated command lines read high through the board pull-ups
  wire logic [6:0] pins = {moe ? {mrd, mwr, emwr} : 3'h7, ioe ? {iord, iowr, eiowr, iack} : 4'hf};

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // active-low pins {mrd, mwr, emwr, iord, iowr, eiowr, iack} for each code
  function automatic logic [6:0] decode(input logic [2:0] c);
    case (c)
      3'h0: decode = 7'h7e;
      3'h1: decode = 7'h77;
      3'h2: decode = 7'h79;
      3'h4, 3'h5: decode = 7'h3f;
      3'h6: decode = 7'h4f;
      default: decode = 7'h7f;
    endcase
  endfunction : decode

  // one machine cycle, then back to passive
  task automatic bus_cycle(input logic [2:0] code, input logic [6:0] exp);
    int   n;
    logic act;
    act = code != 3'h3 && code != 3'h7;
    n = 0;
    i_bcc_proc_model.put_status(code);
    while (act && ale !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    check("address strobe", ale, act);
    if (!strap && qual) check("cascade gate", cope, act && code == 3'h0);
    repeat (4) @(posedge mclk);
    check("command pins", pins, exp);
    if (act) check("direction", dir, code[1] && !code[0]);
    check("transceiver enable", xen, act && qual && !(strap && code < 3'h3));
    if (strap) check("peripheral enable", cope, !(act && qual && code < 3'h3));
    i_bcc_proc_model.put_status(3'h7);
    repeat (8) @(posedge mclk);
    check("idle pins", pins, 7'h7f);
  endtask : bus_cycle

  // all eight codes; float_mask marks lines whose drivers should be off
  task automatic sweep(input logic [6:0] float_mask);
    for (int c = 0; c < 8; c++) begin
      bus_cycle(3'(c), qual ? (decode(3'(c)) | float_mask) : 7'h7f);
    end
  endtask : sweep

  // main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    int          n;
    rstn        = 1'b0;
    qual        = 1'b1;
    strap       = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0000_0000;
    err_count   = 0;
    checks_done = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (8) @(posedge mclk);
    apb(1'b0, `BCC_REG_CTRL, 32'h0000_0000, q, e);
    check("ctrl reset", q, `BCC_CTRL_RESET);
    apb(1'b1, `BCC_REG_CTRL, 32'h0000_0001, q, e);
    apb(1'b0, `BCC_REG_CTRL, 32'h0000_0000, q, e);
    check("ctrl readback", q, 32'h0000_0001);
    apb(1'b1, `BCC_REG_CTRL, 32'h0000_0000, q, e);
    apb(1'b0, `BCC_REG_STATUS, 32'h0000_0000, q, e);
    check("status pins", q[8:6], 3'h3);
    apb(1'b0, 12'h008, 32'h0000_0000, q, e);
    check("unmapped error", e, 1'b1);
    check("unmapped data", q, 32'h0000_0000);
    i_bcc_proc_model.set_grant(1'b0);
    n = 0;
    while (moe !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    check("grant delay", n > 14 && n < 33, 1'b1);
    sweep(7'h00);
    // cascade gate masked on the first acknowledge of a pair only
    apb(1'b1, `BCC_REG_CTRL, 32'h0000_0001, q, e);
    for (int k = 0; k < 2; k++) begin
      i_bcc_proc_model.put_status(3'h0);
      repeat (6) @(posedge mclk);
      check("paired cascade gate", cope, k);
      i_bcc_proc_model.put_status(3'h7);
      repeat (8) @(posedge mclk);
    end
    apb(1'b1, `BCC_REG_CTRL, 32'h0000_0000, q, e);
    qual <= 1'b0;
    repeat (8) @(posedge mclk);
    sweep(7'h00);
    qual <= 1'b1;
    i_bcc_proc_model.set_grant(1'b1);
    repeat (6) @(posedge mclk);
    check("memory drivers off", moe, 1'b0);
    sweep(7'h7f);
    strap <= 1'b1;
    repeat (8) @(posedge mclk);
    check("io drivers on", ioe, 1'b1);
    sweep(7'h70);
    end_of_test();
  end

  // the run needs well under a thousand cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_of_test();
  end
endmodule : bus_command_controller_test
